/* File: sdfe_pkg.sv */
// Purpose: shared constants and types of the sigma-delta serial front end
// Assumes: one kernel clock at 250 MHz, synchronous active-low reset
// Notes: field encodings, counter widths and reset values live here
package sdfe_pkg;

  // kernel clock period in ns, for reference by users of the package
  localparam int CLK_PERIOD_NS = 4;

  // channel count and per-channel field widths
  localparam int NUM_CH = 8;
  localparam int CH_IDX_W = 3;

  // interface type field encodings
  localparam logic [1:0] SIT_SPI_RISE = 2'h0;
  localparam logic [1:0] SIT_SPI_FALL = 2'h1;
  localparam logic [1:0] SIT_MAN_RISE_ZERO = 2'h2;
  localparam logic [1:0] SIT_MAN_RISE_ONE = 2'h3;

  // spi clock source field encodings
  localparam logic [1:0] SPICK_EXT = 2'h0;
  localparam logic [1:0] SPICK_OUT = 2'h1;
  localparam logic [1:0] SPICK_HALF_RISE = 2'h2;
  localparam logic [1:0] SPICK_HALF_FALL = 2'h3;

  // output clock stop: 4 kernel clocks, or 1 kernel clock plus 3 audio clocks
  localparam logic [2:0] DRAIN_DONE = 3'h4;
  localparam logic [2:0] DRAIN_RST = 3'h0;

  // manchester interval counter width, saturating
  localparam int MAN_CNT_W = 9;
  localparam logic [MAN_CNT_W-1:0] MAN_CNT_MAX = 9'h1ff;

  // conversion duration counter
  localparam int DUR_W = 28;
  localparam logic [DUR_W-1:0] DUR_RST = 28'h000_0000;
  localparam logic [DUR_W-1:0] DUR_MAX = 28'hfff_ffff;

  // expected input clock count width
  localparam int EXP_W = 20;
  localparam logic [EXP_W-1:0] EXP_RST = 20'h0_0000;
  localparam logic [EXP_W-1:0] FASTSINC_ORDER = 20'h0_0004;
  localparam logic [EXP_W-1:0] FASTSINC_TAIL = 20'h0_0002;

  // sample stream buffer
  localparam int SAMPLE_W = 4;
  localparam int FIFO_DEPTH = 16;

  // output clock generator states
  typedef enum logic [1:0] {CK_OFF, CK_RUN, CK_DRAIN} ckstate_e;

endpackage : sdfe_pkg

/* File: sample_fifo.sv */
// Purpose: sample buffer with valid/ready on both sides and a registered head
// Assumes: single clock, synchronous active-low reset
// Notes: in_ready_o is low exactly when the array holds DEPTH words
`timescale 1ns/100ps
module sample_fifo #(
  parameter int WIDTH = 4,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [WIDTH-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH]; // storage array
  logic [PW-1:0] wr_q, wr_d; // write pointer
  logic [PW-1:0] rd_q, rd_d; // read pointer
  logic [CW-1:0] cnt_q, cnt_d; // words held in the array
  logic ov_q, ov_d; // head register valid
  logic [WIDTH-1:0] od_q, od_d; // head register data
  logic push, pop; // array transfers

  // next-state: the head register refills from the array whenever it empties
  always_comb begin
    push = in_valid_i && (cnt_q != DEPTH_C);
    pop = (cnt_q != '0) && (!ov_q || out_ready_i);
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + CW'(push) - CW'(pop);
    ov_d = pop ? 1'b1 : (out_ready_i ? 1'b0 : ov_q);
    od_d = pop ? mem[rd_q] : od_q;
  end

  // registers; the array itself needs no reset
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
      ov_q <= 1'b0;
      od_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
      ov_q <= ov_d;
      od_q <= od_d;
    end
  end

  // array write port
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end

  assign in_ready_o = (cnt_q != DEPTH_C);
  assign out_valid_o = ov_q;
  assign out_data_o = od_q;
endmodule : sample_fifo

/* File: sigma_delta_serial_frontend.sv */
// Purpose: serial front end: output clock, 8 spi/manchester receivers, duration timer
// Assumes: pins and the audio clock are asynchronous; config ports are on CLK_I
// Notes: received bits leave as {channel, bit} words through a 16-word buffer
`timescale 1ns/100ps
module sigma_delta_serial_frontend
  import sdfe_pkg::*;
(
  // clock and reset
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic AUDIO_CLK_I,
  // global and clock control
  input wire logic GLOBAL_UNIT_ENABLE_I,
  input wire logic OUT_CLOCK_SOURCE_SELECT_I,
  input wire logic [7:0] OUT_CLOCK_DIVIDER_I,
  output logic OUT_CLOCK_O,
  output logic OUT_CLOCK_ACTIVE_O,
  // channel control and status
  input wire logic [NUM_CH-1:0] CHANNEL_ENABLE_I,
  input wire logic [2*NUM_CH-1:0] SERIAL_INTERFACE_TYPE_I,
  input wire logic [2*NUM_CH-1:0] SPI_CLOCK_SOURCE_SELECT_I,
  input wire logic [NUM_CH-1:0] CLOCK_LOSS_FLAG_CLEAR_I,
  output logic [NUM_CH-1:0] CLOCK_LOSS_FLAG_O,
  // serial pins
  input wire logic [NUM_CH-1:0] EXT_SERIAL_CLOCK_IN_I,
  input wire logic [NUM_CH-1:0] SERIAL_DATA_IN_I,
  // received bit stream
  output logic SAMPLE_VALID_O,
  output logic [SAMPLE_W-1:0] SAMPLE_DATA_O,
  input wire logic SAMPLE_READY_I,
  // conversion timing
  input wire logic CONV_TRIGGER_I,
  input wire logic CONV_END_I,
  input wire logic [CH_IDX_W-1:0] MEAS_CHANNEL_I,
  input wire logic [9:0] FILTER_OVERSAMPLING_RATIO_I,
  input wire logic [7:0] INTEGRATOR_OVERSAMPLING_RATIO_I,
  input wire logic [2:0] FILTER_ORDER_I,
  input wire logic FAST_SINC_I,
  input wire logic FAST_CONT_I,
  output logic [DUR_W-1:0] CONVERSION_DURATION_COUNT_O,
  output logic [EXP_W-1:0] EXPECTED_INPUT_CLOCKS_O
);

  // input clocks per conversion from the filter settings
  function automatic logic [EXP_W-1:0] conv_clocks(input logic [9:0] filter_oversampling_ratio_f,
      input logic [7:0] ior_f, input logic [2:0] filter_order, input logic fastsinc,
      input logic later);
    logic [EXP_W-1:0] filter_oversampling_ratio;
    logic [EXP_W-1:0] integrator_oversampling_ratio;
    filter_oversampling_ratio = EXP_W'(filter_oversampling_ratio_f) + 1'b1;
    integrator_oversampling_ratio = EXP_W'(ior_f) + 1'b1;
    if (filter_oversampling_ratio_f == '0) begin
      conv_clocks = integrator_oversampling_ratio;
    end else if (later) begin
      conv_clocks = EXP_W'(filter_oversampling_ratio * integrator_oversampling_ratio);
    end else if (fastsinc) begin
      conv_clocks = EXP_W'(filter_oversampling_ratio * (integrator_oversampling_ratio - 1'b1 + FASTSINC_ORDER)) + FASTSINC_TAIL;
    end else begin
      conv_clocks = EXP_W'(filter_oversampling_ratio * (integrator_oversampling_ratio - 1'b1 + EXP_W'(filter_order))) + EXP_W'(filter_order);
    end
  endfunction : conv_clocks

  // lowest pending channel: {found, index}
  function automatic logic [CH_IDX_W:0] pick(input logic [NUM_CH-1:0] p);
    pick = '0;
    for (int k = NUM_CH - 1; k >= 0; k--) begin
      if (p[k]) begin
        pick = {1'b1, CH_IDX_W'(k)};
      end
    end
  endfunction : pick

  // ---------------- output clock generator ----------------
  logic au_m, au_s, au_p; // audio clock synchroniser and edge history
  logic audio_edge; // one rising audio edge seen
  ckstate_e ck_q, ck_d; // generator state
  logic [7:0] div_q, div_d; // divider phase
  logic [2:0] drain_q, drain_d; // clocks counted since the disable
  logic sel_q, sel_d; // source latched while stopped
  logic ckout_q, ckout_d; // output clock level
  logic orise_q, orise_d; // output clock rose this cycle
  logic ofall_q, ofall_d; // output clock fell this cycle
  logic adv; // divider advance enable
  logic div_zero;
  logic act_q, act_d; // generator running or draining, kept in a flop for the pin

  // next-state of the output clock; the source only moves while stopped
  always_comb begin
    audio_edge = au_s & ~au_p;
    div_zero = (OUT_CLOCK_DIVIDER_I == 8'h00);
    adv = sel_q ? audio_edge : 1'b1;
    ck_d = ck_q;
    drain_d = drain_q;
    sel_d = sel_q;
    div_d = div_q;
    case (ck_q)
      CK_OFF: begin
        sel_d = OUT_CLOCK_SOURCE_SELECT_I;
        div_d = 8'h00;
        drain_d = DRAIN_RST;
        if (GLOBAL_UNIT_ENABLE_I && !div_zero) begin
          ck_d = CK_RUN;
        end
      end
      CK_RUN: begin
        if (div_zero) begin
          ck_d = CK_OFF;
        end else if (!GLOBAL_UNIT_ENABLE_I) begin
          ck_d = CK_DRAIN;
          drain_d = DRAIN_RST + 1'b1;
        end
      end
      default: begin
        // first drain clock is a kernel clock either way, then audio clocks when audio-sourced, kernel clocks otherwise
        drain_d = drain_q + 3'((sel_q ? audio_edge : 1'b1));
        if (drain_d == DRAIN_DONE || div_zero) begin
          ck_d = CK_OFF;
        end
      end
    endcase
    if (ck_q != CK_OFF && adv) begin
      div_d = (div_q >= OUT_CLOCK_DIVIDER_I) ? 8'h00 : div_q + 1'b1;
    end
    ckout_d = (ck_d != CK_OFF) && !div_zero && (div_d <= (OUT_CLOCK_DIVIDER_I >> 1));
    orise_d = ckout_d & ~ckout_q;
    ofall_d = ~ckout_d & ckout_q;
    act_d = (ck_d != CK_OFF);
  end

  // output clock registers; reset restarts the divider
  always_ff @(posedge CLK_I) begin
    au_m <= AUDIO_CLK_I;
    au_s <= au_m;
    au_p <= au_s;
    if (!RST_N_I) begin
      ck_q <= CK_OFF;
      div_q <= 8'h00;
      drain_q <= DRAIN_RST;
      sel_q <= 1'b0;
      ckout_q <= 1'b0;
      orise_q <= 1'b0;
      ofall_q <= 1'b0;
      act_q <= 1'b0;
    end else begin
      ck_q <= ck_d;
      div_q <= div_d;
      drain_q <= drain_d;
      sel_q <= sel_d;
      ckout_q <= ckout_d;
      orise_q <= orise_d;
      ofall_q <= ofall_d;
      act_q <= act_d;
    end
  end

  assign OUT_CLOCK_O = ckout_q;
  assign OUT_CLOCK_ACTIVE_O = act_q;

  chk_div_zero_low: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (OUT_CLOCK_DIVIDER_I == 8'h00) |=> !OUT_CLOCK_O)
    else $error("output clock not low with divider zero");
  sequence kernel_drain_start;
    ck_q == CK_RUN && !GLOBAL_UNIT_ENABLE_I && !sel_q && !div_zero;
  endsequence
  chk_stop_kernel: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      kernel_drain_start ##1 (!div_zero [*3]) |=> (ck_q == CK_OFF && !OUT_CLOCK_O))
    else $error("kernel-sourced clock did not stop after four clocks");
  chk_stop_audio: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (ck_q == CK_DRAIN && sel_q && drain_q == 3'h3 && audio_edge) |=> ck_q == CK_OFF)
    else $error("audio-sourced clock did not stop on third audio clock");
  chk_audio_steps: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (ck_q != CK_OFF && sel_q && !audio_edge) |=> $stable(div_q))
    else $error("divider advanced without an audio edge");

  // ---------------- serial receivers ----------------
  wire [NUM_CH-1:0] flag_w; // loss flags
  wire [NUM_CH-1:0] samp_w; // a bit was sampled this cycle
  wire [NUM_CH-1:0] pend_w; // bit waiting for the buffer
  wire [NUM_CH-1:0] bit_w; // waiting bit value
  logic [CH_IDX_W:0] sel_ch; // arbiter choice
  logic [NUM_CH-1:0] grant; // one-hot take into the buffer
  logic fifo_ready; // buffer can take a word

  // lowest channel wins the buffer; other pending bits wait their turn
  always_comb begin
    sel_ch = pick(pend_w);
    grant = '0;
    if (sel_ch[CH_IDX_W] && fifo_ready) begin
      grant[sel_ch[CH_IDX_W-1:0]] = 1'b1;
    end
  end

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    logic ck_m, ck_s, ck_p; // clock pin synchroniser and history
    logic dt_m, dt_s, dt_p; // data pin synchroniser and history
    logic sync_q, sync_d; // receiver synchronised
    logic flag_q, flag_d; // clock loss flag
    logic par_q, par_d; // halved-clock phase
    logic pend_q, pend_d; // sampled bit awaiting the buffer
    logic bit_q, bit_d; // sampled bit value
    logic [MAN_CNT_W-1:0] mc_q, mc_d; // kernel clocks since last mid-bit edge
    logic en, clk_seen, samp, sbit, half_edge, mid, d_edge;
    logic [1:0] styp, ssrc;

    // sampling point selection per source and interface type
    always_comb begin
      en = GLOBAL_UNIT_ENABLE_I & CHANNEL_ENABLE_I[i];
      styp = SERIAL_INTERFACE_TYPE_I[2*i +: 2];
      ssrc = SPI_CLOCK_SOURCE_SELECT_I[2*i +: 2];
      d_edge = dt_s ^ dt_p;
      half_edge = (ssrc == SPICK_HALF_RISE) ? ofall_q : orise_q;
      mid = 1'b0;
      sbit = dt_s;
      mc_d = (mc_q == MAN_CNT_MAX) ? mc_q : mc_q + 1'b1;
      if (styp[1]) begin
        // only the data pin is used; a long interval marks a mid-bit edge
        clk_seen = d_edge;
        mid = d_edge && sync_q && (mc_q > MAN_CNT_W'(OUT_CLOCK_DIVIDER_I));
        samp = mid;
        sbit = (styp == SIT_MAN_RISE_ONE) ? dt_s : ~dt_s;
        if (d_edge && (!sync_q || mid)) begin
          mc_d = '0;
        end
      end else begin
        case (ssrc)
          SPICK_EXT: begin
            clk_seen = ck_s ^ ck_p;
            samp = (styp == SIT_SPI_FALL) ? (ck_p & ~ck_s) : (ck_s & ~ck_p);
          end
          SPICK_OUT: begin
            clk_seen = orise_q | ofall_q;
            samp = (styp == SIT_SPI_FALL) ? ofall_q : orise_q;
          end
          default: begin
            clk_seen = half_edge;
            samp = half_edge & par_q;
          end
        endcase
      end
      samp = samp & sync_q & en;
      sync_d = en & (sync_q | clk_seen);
      // a clear only lands once synchronised; loss of sync sets the flag
      flag_d = ~sync_d | (flag_q & ~CLOCK_LOSS_FLAG_CLEAR_I[i]);
      par_d = sync_d & (par_q ^ (half_edge & sync_q));
      pend_d = (pend_q & ~grant[i]) | samp;
      bit_d = samp ? sbit : bit_q;
    end

    // receiver registers
    always_ff @(posedge CLK_I) begin
      ck_m <= EXT_SERIAL_CLOCK_IN_I[i];
      ck_s <= ck_m;
      ck_p <= ck_s;
      dt_m <= SERIAL_DATA_IN_I[i];
      dt_s <= dt_m;
      dt_p <= dt_s;
      if (!RST_N_I) begin
        sync_q <= 1'b0;
        flag_q <= 1'b1;
        par_q <= 1'b0;
        pend_q <= 1'b0;
        bit_q <= 1'b0;
        mc_q <= '0;
      end else begin
        sync_q <= sync_d;
        flag_q <= flag_d;
        par_q <= par_d;
        pend_q <= pend_d;
        bit_q <= bit_d;
        mc_q <= mc_d;
      end
    end

    assign flag_w[i] = flag_q;
    assign samp_w[i] = samp;
    assign pend_w[i] = pend_q;
    assign bit_w[i] = bit_q;

    chk_flag_unsync: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (!sync_q && CLOCK_LOSS_FLAG_CLEAR_I[i]) |=> flag_q || sync_q)
      else $error("clock loss flag cleared while unsynchronised");
    chk_flag_clear: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (sync_q && en && CLOCK_LOSS_FLAG_CLEAR_I[i]) ##1 sync_q |-> !flag_q)
      else $error("clock loss flag not cleared after synchronisation");
    chk_spi_sync: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
        (en && !styp[1] && ssrc == SPICK_EXT && (ck_s ^ ck_p)) ##1 en |-> sync_q)
      else $error("spi channel did not synchronise on first clock edge");
  end

  assign CLOCK_LOSS_FLAG_O = flag_w;

  // the buffer stalls the arbiter; a channel sampling again while its bit
  // still waits overwrites it, so the drain side must keep up
  sample_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .in_valid_i(sel_ch[CH_IDX_W]),
    .in_data_i({sel_ch[CH_IDX_W-1:0], bit_w[sel_ch[CH_IDX_W-1:0]]}),
    .in_ready_o(fifo_ready),
    .out_valid_o(SAMPLE_VALID_O),
    .out_data_o(SAMPLE_DATA_O),
    .out_ready_i(SAMPLE_READY_I)
  );

  // ---------------- conversion duration timer ----------------
  logic armed_q, armed_d; // trigger seen, waiting for first sample
  logic run_q, run_d; // counting kernel clocks
  logic later_q, later_d; // a fast continuous conversion already ended
  logic [DUR_W-1:0] cnt_q, cnt_d; // clocks since first sample
  logic [DUR_W-1:0] last_q, last_d; // count at most recent sample
  logic [DUR_W-1:0] dur_q, dur_d; // published duration
  logic [EXP_W-1:0] exp_q, exp_d; // expected input clocks
  logic meas_samp, bypass;

  // counting keeps running through channel disable, so gaps are included
  always_comb begin
    meas_samp = samp_w[MEAS_CHANNEL_I];
    bypass = (FILTER_OVERSAMPLING_RATIO_I == 10'h000);
    armed_d = armed_q;
    run_d = run_q;
    cnt_d = (cnt_q == DUR_MAX) ? cnt_q : cnt_q + 1'b1;
    last_d = last_q;
    dur_d = dur_q;
    later_d = later_q & FAST_CONT_I;
    if (CONV_TRIGGER_I) begin
      armed_d = 1'b1;
      run_d = 1'b0;
    end else if (armed_q && meas_samp) begin
      armed_d = 1'b0;
      run_d = 1'b1;
      cnt_d = DUR_RST;
      last_d = DUR_RST;
    end else if (run_q && meas_samp) begin
      last_d = cnt_d;
    end
    if (CONV_END_I) begin
      dur_d = (bypass || !run_q) ? DUR_RST : last_d;
      armed_d = 1'b0;
      run_d = 1'b0;
      later_d = FAST_CONT_I;
    end
    exp_d = conv_clocks(FILTER_OVERSAMPLING_RATIO_I, INTEGRATOR_OVERSAMPLING_RATIO_I,
                        FILTER_ORDER_I, FAST_SINC_I, later_q);
  end

  // duration registers
  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      armed_q <= 1'b0;
      run_q <= 1'b0;
      later_q <= 1'b0;
      cnt_q <= DUR_RST;
      last_q <= DUR_RST;
      dur_q <= DUR_RST;
      exp_q <= EXP_RST;
    end else begin
      armed_q <= armed_d;
      run_q <= run_d;
      later_q <= later_d;
      cnt_q <= cnt_d;
      last_q <= last_d;
      dur_q <= dur_d;
      exp_q <= exp_d;
    end
  end

  assign CONVERSION_DURATION_COUNT_O = dur_q;
  assign EXPECTED_INPUT_CLOCKS_O = exp_q;

  chk_bypass_zero: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (CONV_END_I && bypass) |=> CONVERSION_DURATION_COUNT_O == DUR_RST)
    else $error("bypassed conversion reported nonzero duration");
  chk_dur_load: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (CONV_END_I && !bypass && run_q && !meas_samp) |=> dur_q == $past(last_q))
    else $error("duration not loaded from last sample count");

endmodule : sigma_delta_serial_frontend

/* File: sd_modulator.sv */
// Purpose: behavioural modulator driving the serial clock and data pins
// Assumes: serial clock made from the kernel clock at a quarter of its rate or less
// Notes: while stopped the clock stands low and data shows the inverse level
`timescale 1ns/100ps
module sd_modulator #(
  parameter int HALF = 4
) (
  // timing reference
  input wire logic clk_i,
  // control
  input wire logic run_i,
  input wire logic level_i,
  input wire logic man_i,
  // pins
  output logic [7:0] ser_clk_o,
  output logic [7:0] ser_data_o
);
  // manchester half bit of 16 kernel clocks keeps the bit clock under 10 MHz
  localparam int MAN_HALF = 4 * HALF;
  int cnt = 0; // kernel cycles in this half period
  logic ck = 1'b0; // shared serial clock
  // toggle only while running, so no stray edges appear between frames
  always @(posedge clk_i) begin
    if (!run_i) begin
      ck <= 1'b0;
      cnt <= 0;
    end else if (cnt == (man_i ? MAN_HALF : HALF) - 1) begin
      ck <= ~ck;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  assign ser_clk_o = {8{ck}};
  // released data must not look like the last value
  // manchester: the first change after start is a mid-bit edge toward the level
  assign ser_data_o = !run_i ? {8{~level_i}} : (man_i ? {8{ck ^ ~level_i}} : {8{level_i}});
endmodule : sd_modulator

/* File: testbench.sv */
// Purpose: self-checking bench of the serial front end
// Assumes: external serial clock at one eighth of the kernel clock
// Notes: tests drive at rising edges or 1 ns after them and sample 1 ns after an edge
`timescale 1ns/100ps
module testbench;
  import sdfe_pkg::*;
  logic clk = 1'b0, aclk = 1'b0, rst_n = 1'b0, glob = 1'b0, run = 1'b0, lvl = 1'b1;
  logic man = 1'b0, osel = 1'b0, fcont = 1'b0;
  logic [15:0] styp = 16'h0000;
  logic [7:0] div = 8'h00, channel_enable = 8'h00, clr = 8'h00;
  logic rdy = 1'b1, trig = 1'b0, cend = 1'b0, fsinc = 1'b0;
  logic [9:0] filter_oversampling_ratio = 10'h000;
  logic [7:0] integrator_oversampling_ratio = 8'h00;
  logic [2:0] ord = 3'h0;
  logic [7:0] sck, sdat, flag;
  logic ock, oact, sval;
  logic [SAMPLE_W-1:0] sdata;
  logic [DUR_W-1:0] dur;
  logic [EXP_W-1:0] expc;
  int n_mismatch = 0, checked = 0;
  // kernel clock 250 MHz and an unrelated slower audio clock
  initial forever #2 clk = ~clk;
  // audio edges sit 1 ns off the kernel edges, so their sampling is race free
  initial begin
    #1;
    forever #10 aclk = ~aclk;
  end
  sd_modulator #(.HALF(4)) modl (.clk_i(clk), .run_i(run), .level_i(lvl), .man_i(man),
    .ser_clk_o(sck), .ser_data_o(sdat));
  sigma_delta_serial_frontend dut (.CLK_I(clk), .RST_N_I(rst_n), .AUDIO_CLK_I(aclk),
    .GLOBAL_UNIT_ENABLE_I(glob), .OUT_CLOCK_SOURCE_SELECT_I(osel),
    .OUT_CLOCK_DIVIDER_I(div), .OUT_CLOCK_O(ock), .OUT_CLOCK_ACTIVE_O(oact),
    .CHANNEL_ENABLE_I(channel_enable), .SERIAL_INTERFACE_TYPE_I(styp),
    .SPI_CLOCK_SOURCE_SELECT_I(16'h0000), .CLOCK_LOSS_FLAG_CLEAR_I(clr),
    .CLOCK_LOSS_FLAG_O(flag), .EXT_SERIAL_CLOCK_IN_I(sck), .SERIAL_DATA_IN_I(sdat),
    .SAMPLE_VALID_O(sval), .SAMPLE_DATA_O(sdata), .SAMPLE_READY_I(rdy),
    .CONV_TRIGGER_I(trig), .CONV_END_I(cend), .MEAS_CHANNEL_I(3'h0),
    .FILTER_OVERSAMPLING_RATIO_I(filter_oversampling_ratio), .INTEGRATOR_OVERSAMPLING_RATIO_I(integrator_oversampling_ratio),
    .FILTER_ORDER_I(ord), .FAST_SINC_I(fsinc), .FAST_CONT_I(fcont),
    .CONVERSION_DURATION_COUNT_O(dur), .EXPECTED_INPUT_CLOCKS_O(expc));
  // wait n edges, then let their updates settle
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  // compare with case equality so an unknown never matches
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one-cycle pulse on a control input
  task pulse(input int which);
    @(posedge clk);
    if (which == 0) clr <= 8'hff; else if (which == 1) trig <= 1'b1; else cend <= 1'b1;
    @(posedge clk);
    clr <= 8'h00;
    trig <= 1'b0;
    cend <= 1'b0;
    tick(2);
  endtask : pulse
  // kernel clocks of one whole output clock period, skipping the first one
  task out_period(output int n);
    while (ock !== 1'b1) tick(1);
    while (ock !== 1'b0) tick(1);
    while (ock !== 1'b1) tick(1);
    n = 0;
    do begin
      tick(1);
      n++;
    end while (ock !== 1'b0);
    while (ock !== 1'b1) begin
      tick(1);
      n++;
    end
  endtask : out_period
  // clear the global enable, count kernel clocks until the generator is off
  task stop_count(output int n);
    @(posedge clk);
    glob <= 1'b0;
    n = 0;
    do begin
      tick(1);
      n++;
    end while (oact !== 1'b0 && n < 40);
  endtask : stop_count
  task t_reset;
    chk({ock, oact, sval, flag}, {3'h0, 8'hff});
    chk(dur, 0);
    $display("test reset done");
  endtask : t_reset
  task t_outclk;
    int n;
    n = 0;
    @(posedge clk);
    glob <= 1'b1;
    repeat (20) begin
      tick(1);
      if (ock !== 1'b0 || oact !== 1'b0) n++;
    end
    chk(n, 0);
    @(posedge clk);
    div <= 8'h02;
    out_period(n);
    chk(n, 3);
    stop_count(n);
    chk(n, 4);
    chk(ock, 0);
    // the source moves only while the generator stands still
    @(posedge clk);
    osel <= 1'b1;
    tick(2);
    @(posedge clk);
    glob <= 1'b1;
    // three audio steps of five kernel clocks each
    out_period(n);
    chk(n, 15);
    // one kernel clock, then three audio edges that arrive every five clocks
    stop_count(n);
    chk(n >= 12 && n <= 16, 1);
    @(posedge clk);
    osel <= 1'b0;
    tick(2);
    @(posedge clk);
    glob <= 1'b1;
    $display("test output clock done");
  endtask : t_outclk
  task t_sync;
    @(posedge clk);
    channel_enable <= 8'h01;
    tick(6);
    pulse(0);
    chk(flag, 8'hff);
    run <= 1'b1;
    tick(30);
    pulse(0);
    chk(flag, 8'hfe);
    while (sval !== 1'b1) tick(1);
    chk(sdata, 4'h1);
    channel_enable <= 8'h00;
    tick(3);
    chk(flag, 8'hff);
    $display("test sync done");
  endtask : t_sync
  task t_dur;
    @(posedge clk);
    channel_enable <= 8'h01;
    filter_oversampling_ratio <= 10'h003;
    tick(30);
    pulse(1);
    tick(100);
    pulse(2);
    chk(dur % 32'd8, 0);
    chk(dur > 32'd0, 1);
    filter_oversampling_ratio <= 10'h000;
    pulse(1);
    tick(100);
    pulse(2);
    chk(dur, 0);
    $display("test duration done");
  endtask : t_dur
  task t_fifo;
    int n, idle;
    logic bad;
    n = 0;
    idle = 0;
    bad = 1'b0;
    // stall the consumer while all eight channels keep sampling
    rdy <= 1'b0;
    channel_enable <= 8'hff;
    tick(400);
    run <= 1'b0;
    tick(10);
    rdy <= 1'b1;
    while (idle < 5) begin
      tick(1);
      if (sval === 1'b1) begin
        n++;
        bad = bad | ~sdata[0];
        idle = 0;
      end else idle++;
    end
    chk(n >= FIFO_DEPTH + 1 && n <= FIFO_DEPTH + 9, 1);
    chk(bad, 0);
    $display("test buffer done");
  endtask : t_fifo
  // channel 0 decodes rising as one, channel 1 rising as zero, same data pin
  task t_manch;
    int n1, n2, nbad;
    n1 = 0;
    n2 = 0;
    nbad = 0;
    @(posedge clk);
    channel_enable <= 8'h00;
    styp <= 16'h000b;
    div <= 8'h14;
    man <= 1'b1;
    tick(3);
    @(posedge clk);
    channel_enable <= 8'h03;
    tick(3);
    @(posedge clk);
    run <= 1'b1;
    repeat (400) begin
      tick(1);
      if (sval === 1'b1) begin
        if (sdata === 4'h1) n1++;
        else if (sdata === 4'h2) n2++;
        else nbad++;
      end
    end
    chk(nbad, 0);
    chk(n1 >= 8 && n1 <= 14, 1);
    chk(n2 >= 8 && n2 <= 14, 1);
    pulse(0);
    chk(flag, 8'hfc);
    @(posedge clk);
    run <= 1'b0;
    channel_enable <= 8'h00;
    man <= 1'b0;
    styp <= 16'h0000;
    $display("test manchester done");
  endtask : t_manch
  task t_expect;
    logic [9:0] fs [3] = '{10'h003, 10'h003, 10'h000};
    logic [31:0] ex [3] = '{32'd19, 32'd22, 32'd5};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      filter_oversampling_ratio <= fs[i];
      integrator_oversampling_ratio <= (i == 2) ? 8'h04 : 8'h01;
      ord <= 3'h3;
      fsinc <= (i == 1);
      tick(3);
      chk(expc, ex[i]);
    end
    // a fast continuous conversion that follows another takes ratio times ratio
    @(posedge clk);
    filter_oversampling_ratio <= 10'h003;
    integrator_oversampling_ratio <= 8'h01;
    fcont <= 1'b1;
    pulse(2);
    chk(expc, 32'd8);
    $display("test expected clocks done");
  endtask : t_expect
  task give_verdict;
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict
  // cut a hang short after well over the expected run length
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    $display("watchdog expired");
    give_verdict();
  end
  initial begin
    tick(10);
    rst_n <= 1'b1;
    tick(1);
    t_reset();
    t_outclk();
    t_sync();
    t_dur();
    t_fifo();
    t_manch();
    t_expect();
    give_verdict();
  end
endmodule : testbench
